// [pkg/hpcb_pkg.sv]
// constants and types shared by the hot-plug control bus interface
package hpcb_pkg;

    localparam int         DATA_W    = 8;
    localparam int         IDX_W     = 5;
    localparam int         SADR_W    = 7;
    localparam int         NUM_REGS  = 32;
    localparam int         SYNC_W    = 2;
    localparam int         TOG_W     = 3;

    // register index layout: slot in the upper two bits, register in the lower three
    localparam int         REG_LSB   = 0;
    localparam int         REG_MSB   = 2;
    localparam int         SLOT_LSB  = 3;
    localparam int         SLOT_MSB  = 4;

    localparam logic [7:0] REG_RST   = 8'h00;
    localparam logic [4:0] IDX_RST   = 5'h00;
    localparam logic [6:0] SADR_RST  = 7'h00;
    localparam logic [2:0] BIT_FIRST = 3'h1;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    typedef enum logic [3:0] {
        SER_IDLE,
        SER_ADDR,
        SER_AACK,
        SER_IDX,
        SER_IACK,
        SER_WDATA,
        SER_WACK,
        SER_RDATA,
        SER_RACK
    } hpcb_ser_state_t;

endpackage : hpcb_pkg

// [core/hpcb_top.sv]
// control bus interface: parallel host port and two-wire serial slave over shared pins
// Notes on behaviour
// R1: interface select high serves serial access, low serves the parallel bus.
// R2: parallel mode: the three low address pins pick one of eight registers.
// R3: parallel mode: the two upper address pins pick one of four slots.
// R4: serial mode: slave address comes from five address pins plus data bits one and zero.
// R5: active-low chip select qualifies parallel cycles, ignored in serial mode.
// R6: parallel read strobe with chip select returns the addressed register on data.
// R7: parallel write strobe with chip select loads the addressed register from data.
// R8: data bus is received on writes and driven only during reads.
// R9: serial mode: the read strobe pin is the two-way serial data line.
// R10: serial mode: the master drives serial clock on the write strobe pin.
// R11: serial frames: address, register index byte, data; ack only a matching address.
`timescale 1ns/1ps
module hpcb_top (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       INTERFACE_SELECT,
    input  wire logic       REG_INDEX_LO_OR_SERIAL_ADDR_STRAP0,
    input  wire logic       REG_INDEX_MID_OR_SERIAL_ADDR_STRAP1,
    input  wire logic       REG_INDEX_HI_OR_SERIAL_ADDR_STRAP2,
    input  wire logic       SLOT_SELECT_LO_OR_SERIAL_ADDR_STRAP3,
    input  wire logic       SLOT_SELECT_HI_OR_SERIAL_ADDR_STRAP4,
    input  wire logic       CS_N,
    input  wire logic       RD_SDA_I,
    output logic            RD_SDA_O,
    output logic            RD_SDA_OE,
    input  wire logic       WR_SCL,
    input  wire logic [7:0] DATA_I,
    output logic      [7:0] DATA_O,
    output logic            DATA_OE,
    output logic            REG_WE,
    output logic      [4:0] REG_IDX,
    output logic      [7:0] REG_WDATA
);

    // ---------------- host clock domain ----------------
    logic [hpcb_pkg::SYNC_W-1:0] mode_q;
    logic [hpcb_pkg::SYNC_W-1:0] cs_q;
    logic [hpcb_pkg::SYNC_W-1:0] rd_q;
    logic [hpcb_pkg::SYNC_W-1:0] wr_q;
    logic [4:0]                  a_q1;
    logic [4:0]                  a_s;
    logic [7:0]                  d_q1;
    logic [7:0]                  d_s;
    logic                        wr_p_r;
    logic [4:0]                  a_pin;
    logic                        par_mode;
    logic                        par_rd;
    logic                        wr_rise;
    logic                        par_wr;
    logic [7:0]                  rd_mux;
    logic [7:0]                  regs_r [hpcb_pkg::NUM_REGS];
    logic [hpcb_pkg::TOG_W-1:0]  wtg_q;
    logic [hpcb_pkg::TOG_W-1:0]  rtg_q;
    logic                        ser_wr_ev;
    logic                        ser_rd_ev;
    logic [7:0]                  rd_word_r;

    // ---------------- serial clock domain ----------------
    hpcb_pkg::hpcb_ser_state_t   state_r;
    logic [hpcb_pkg::SYNC_W-1:0] interface_select_q;
    logic [6:0]                  strap_q1;
    logic [6:0]                  strap_s;
    logic                        start_tg_r;
    logic                        start_seen_r;
    logic                        start;
    logic [2:0]                  cnt_r;
    logic [7:0]                  sh_r;
    logic [7:0]                  byte_in;
    logic                        rw_r;
    logic [4:0]                  idx_r;
    logic [4:0]                  rq_idx_r;
    logic [4:0]                  wr_idx_r;
    logic [7:0]                  wr_data_r;
    logic [7:0]                  tx_r;
    logic                        rtg_r;
    logic                        wtg_r;
    logic                        addr_end;
    logic                        addr_hit;

    assign a_pin = {SLOT_SELECT_HI_OR_SERIAL_ADDR_STRAP4, SLOT_SELECT_LO_OR_SERIAL_ADDR_STRAP3,
                    REG_INDEX_HI_OR_SERIAL_ADDR_STRAP2, REG_INDEX_MID_OR_SERIAL_ADDR_STRAP1,
                    REG_INDEX_LO_OR_SERIAL_ADDR_STRAP0};

    // pins come from outside the clock domain: two flops before any use
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= 2'h0;
            cs_q   <= 2'h3;
            rd_q   <= 2'h3;
            wr_q   <= 2'h3;
            a_q1   <= hpcb_pkg::IDX_RST;
            a_s    <= hpcb_pkg::IDX_RST;
            d_q1   <= hpcb_pkg::REG_RST;
            d_s    <= hpcb_pkg::REG_RST;
            wr_p_r <= 1'b1;
        end else begin
            mode_q <= {mode_q[0], INTERFACE_SELECT};
            cs_q   <= {cs_q[0], CS_N};
            rd_q   <= {rd_q[0], RD_SDA_I};
            wr_q   <= {wr_q[0], WR_SCL};
            a_q1   <= a_pin;
            a_s    <= a_q1;
            d_q1   <= DATA_I;
            d_s    <= d_q1;
            wr_p_r <= wr_q[1];
        end
    end

    assign par_mode = !mode_q[1];                          // R1
    assign par_rd   = par_mode && !cs_q[1] && !rd_q[1];     // R5 R6
    assign wr_rise  = wr_q[1] && !wr_p_r;
    assign par_wr   = par_mode && !cs_q[1] && wr_rise;      // R5 R7
    // slot bits and register bits together form the flat index
    assign rd_mux   = regs_r[{a_s[hpcb_pkg::SLOT_MSB:hpcb_pkg::SLOT_LSB], a_s[hpcb_pkg::REG_MSB:hpcb_pkg::REG_LSB]}]; // R2 R3

    // serial words are held stable until the next toggle, so only the toggles are synchronised
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wtg_q <= 3'h0;
            rtg_q <= 3'h0;
        end else begin
            wtg_q <= {wtg_q[1:0], wtg_r};
            rtg_q <= {rtg_q[1:0], rtg_r};
        end
    end

    assign ser_wr_ev = wtg_q[2] ^ wtg_q[1];
    assign ser_rd_ev = rtg_q[2] ^ rtg_q[1];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < hpcb_pkg::NUM_REGS; i++) begin
                regs_r[i] <= hpcb_pkg::REG_RST;
            end
        end else if (ser_wr_ev) begin
            regs_r[wr_idx_r] <= wr_data_r;                  // R11
        end else if (par_wr) begin
            regs_r[a_s] <= d_s;                             // R7 R2 R3
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_WE    <= 1'b0;
            REG_IDX   <= hpcb_pkg::IDX_RST;
            REG_WDATA <= hpcb_pkg::REG_RST;
        end else begin
            REG_WE    <= ser_wr_ev || par_wr;
            REG_IDX   <= ser_wr_ev ? wr_idx_r : a_s;
            REG_WDATA <= ser_wr_ev ? wr_data_r : d_s;
        end
    end

    // bus is driven only while a read is active; stale data is harmless because oe is low
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DATA_O  <= hpcb_pkg::REG_RST;
            DATA_OE <= 1'b0;
        end else begin
            DATA_O  <= rd_mux;                              // R6
            DATA_OE <= par_rd;                              // R8
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_word_r <= hpcb_pkg::REG_RST;
        end else if (ser_rd_ev) begin
            rd_word_r <= regs_r[rq_idx_r];
        end
    end

    // ---------------- serial link, clocked by the master's clock ----------------
    // start is an sda fall while scl is high; sampling it directly at the next scl rise
    // relies on the protocol's start hold time rather than on a synchroniser
    always_ff @(negedge RD_SDA_I or negedge RSTN) begin
        if (!RSTN) begin
            start_tg_r <= 1'b0;
        end else if (WR_SCL) begin
            start_tg_r <= ~start_tg_r;
        end
    end

    always_ff @(posedge WR_SCL or negedge RSTN) begin
        if (!RSTN) begin
            interface_select_q      <= 2'h0;
            strap_q1     <= hpcb_pkg::SADR_RST;
            strap_s      <= hpcb_pkg::SADR_RST;
            start_seen_r <= 1'b0;
        end else begin
            interface_select_q      <= {interface_select_q[0], INTERFACE_SELECT};
            strap_q1     <= {DATA_I[1:0], a_pin};           // R4
            strap_s      <= strap_q1;
            start_seen_r <= start_tg_r;
        end
    end

    assign start    = start_tg_r != start_seen_r;
    assign byte_in  = {sh_r[6:0], RD_SDA_I};                // R9
    assign addr_end = interface_select_q[1] && !start && state_r == hpcb_pkg::SER_ADDR && cnt_r == hpcb_pkg::BIT_LAST;
    assign addr_hit = byte_in[7:1] == strap_s;              // R4 R11

    // bits are taken on every rise of the master's serial clock
    always_ff @(posedge WR_SCL or negedge RSTN) begin       // R10
        if (!RSTN) begin
            state_r   <= hpcb_pkg::SER_IDLE;
            cnt_r     <= 3'h0;
            sh_r      <= hpcb_pkg::REG_RST;
            rw_r      <= 1'b0;
            idx_r     <= hpcb_pkg::IDX_RST;
            rq_idx_r  <= hpcb_pkg::IDX_RST;
            wr_idx_r  <= hpcb_pkg::IDX_RST;
            wr_data_r <= hpcb_pkg::REG_RST;
            tx_r      <= hpcb_pkg::REG_RST;
            rtg_r     <= 1'b0;
            wtg_r     <= 1'b0;
        end else if (!interface_select_q[1]) begin
            state_r <= hpcb_pkg::SER_IDLE;                  // R1
        end else if (start) begin
            state_r <= hpcb_pkg::SER_ADDR;
            cnt_r   <= hpcb_pkg::BIT_FIRST;
            sh_r    <= {7'h00, RD_SDA_I};
        end else begin
            case (state_r)
                hpcb_pkg::SER_ADDR: begin
                    sh_r  <= byte_in;
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == hpcb_pkg::BIT_LAST) begin
                        rw_r    <= RD_SDA_I;
                        state_r <= addr_hit ? hpcb_pkg::SER_AACK : hpcb_pkg::SER_IDLE; // R11
                    end
                end
                hpcb_pkg::SER_AACK: begin
                    cnt_r <= 3'h0;
                    if (rw_r) begin
                        state_r  <= hpcb_pkg::SER_RDATA;
                        tx_r     <= rd_word_r;
                        idx_r    <= idx_r + 5'h01;
                        rq_idx_r <= idx_r + 5'h01;
                        rtg_r    <= ~rtg_r;
                    end else begin
                        state_r <= hpcb_pkg::SER_IDX;
                    end
                end
                hpcb_pkg::SER_IDX: begin
                    sh_r  <= byte_in;
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == hpcb_pkg::BIT_LAST) begin
                        idx_r   <= byte_in[4:0];            // R11
                        state_r <= hpcb_pkg::SER_IACK;
                    end
                end
                hpcb_pkg::SER_IACK: begin
                    // prefetch now so a repeated-start read finds its byte waiting
                    rq_idx_r <= idx_r;
                    rtg_r    <= ~rtg_r;
                    state_r  <= hpcb_pkg::SER_WDATA;
                end
                hpcb_pkg::SER_WDATA: begin
                    sh_r  <= byte_in;
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == hpcb_pkg::BIT_LAST) begin
                        wr_data_r <= byte_in;
                        wr_idx_r  <= idx_r;
                        wtg_r     <= ~wtg_r;
                        state_r   <= hpcb_pkg::SER_WACK;
                    end
                end
                hpcb_pkg::SER_WACK: begin
                    idx_r   <= idx_r + 5'h01;
                    state_r <= hpcb_pkg::SER_WDATA;
                end
                hpcb_pkg::SER_RDATA: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == hpcb_pkg::BIT_LAST) begin
                        state_r <= hpcb_pkg::SER_RACK;
                    end
                end
                hpcb_pkg::SER_RACK: begin
                    if (!RD_SDA_I) begin
                        state_r  <= hpcb_pkg::SER_RDATA;
                        tx_r     <= rd_word_r;
                        idx_r    <= idx_r + 5'h01;
                        rq_idx_r <= idx_r + 5'h01;
                        rtg_r    <= ~rtg_r;
                    end else begin
                        state_r <= hpcb_pkg::SER_IDLE;
                    end
                end
                default: begin
                    state_r <= hpcb_pkg::SER_IDLE;
                end
            endcase
        end
    end

    // sda changes only while scl is low; open drain, so the output level is always low
    always_ff @(negedge WR_SCL or negedge RSTN) begin
        if (!RSTN) begin
            RD_SDA_O  <= 1'b0;
            RD_SDA_OE <= 1'b0;
        end else begin
            RD_SDA_O  <= 1'b0;
            RD_SDA_OE <= interface_select_q[1] && (state_r == hpcb_pkg::SER_AACK || state_r == hpcb_pkg::SER_IACK ||
                         state_r == hpcb_pkg::SER_WACK ||
                         (state_r == hpcb_pkg::SER_RDATA && !tx_r[hpcb_pkg::BIT_LAST - cnt_r])); // R9 R11
        end
    end

    // ---------------- checks ----------------
    sequence par_read_s;
        par_mode && !cs_q[1] && !rd_q[1];
    endsequence

    sequence par_write_s;
        par_mode && !cs_q[1] && wr_rise && !ser_wr_ev;
    endsequence

    sequence addr_match_s;
        addr_end && addr_hit;
    endsequence

    sequence addr_miss_s;
        addr_end && !addr_hit;
    endsequence

    read_drive_a: assert property (@(posedge CLK) disable iff (!RSTN) par_read_s |=> DATA_OE) // R6
        else $error("read strobe did not enable the data bus");
    no_drive_a: assert property (@(posedge CLK) disable iff (!RSTN) !par_rd |=> !DATA_OE) // R8
        else $error("data bus driven outside a read");
    read_data_a: assert property (@(posedge CLK) disable iff (!RSTN) par_read_s |=> DATA_O == $past(rd_mux)) // R2
        else $error("read returned the wrong register");
    write_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
        par_write_s |=> REG_WE && REG_IDX == $past(a_s) && REG_WDATA == $past(d_s)) // R7
        else $error("parallel write not loaded to the addressed register");
    cs_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (cs_q[1] || !par_mode) && !ser_wr_ev |=> !REG_WE) // R5
        else $error("write taken without chip select in parallel mode");
    write_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN) REG_WE |=> !REG_WE) // R7
        else $error("write strobe longer than one cycle");
    ser_write_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ser_wr_ev |=> REG_WE && REG_IDX == $past(wr_idx_r) ##1 regs_r[$past(REG_IDX)] == $past(REG_WDATA)) // R11
        else $error("serial write not applied to the register file");
    addr_ack_a: assert property (@(posedge WR_SCL) disable iff (!RSTN) addr_match_s |=> RD_SDA_OE && !RD_SDA_O) // R4
        else $error("matching serial address not acknowledged");
    addr_nack_a: assert property (@(posedge WR_SCL) disable iff (!RSTN) addr_miss_s |=> !RD_SDA_OE [*2]) // R11
        else $error("foreign serial address acknowledged");
    par_quiet_a: assert property (@(posedge WR_SCL) disable iff (!RSTN) !interface_select_q[1] |=> !RD_SDA_OE) // R1
        else $error("serial data driven in parallel mode");

endmodule : hpcb_top

// [testbench/hpcb_host.sv]
// host model: parallel bus master and two-wire serial master
`timescale 1ns/1ps
module hpcb_host (
    input  wire logic       clk,
    input  wire logic       sda_w,
    input  wire logic [7:0] data_w,
    output logic            cs_n   = 1'b1,
    output logic            rd_sda = 1'b1,
    output logic            wr_scl = 1'b1,
    output logic      [4:0] addr   = 5'h00,
    output logic      [7:0] hd     = 8'h00
);
    task automatic straps(input logic [6:0] a);
        addr = a[4:0];
        hd   = {6'h2a, a[6:5]};
    endtask : straps
    // released data lines show the inverse of their last value, so a silent device cannot look right
    task automatic par_cycle(input logic [4:0] a, input logic [7:0] d, input logic sel_n, input logic rd,
                             output logic [7:0] q);
        @(negedge clk);
        addr = a;
        hd   = rd ? ~hd : d;
        cs_n = sel_n;
        repeat (3) @(negedge clk);
        rd_sda = ~rd;
        wr_scl = rd;
        repeat (5) @(negedge clk);
        q      = data_w;
        rd_sda = 1'b1;
        wr_scl = 1'b1;
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        hd   = ~hd;
    endtask : par_cycle
    // scl period 160 ns; sda moves 40 ns after scl falls, sampled 40 ns after it rises
    task automatic ser_bit(input logic b, output logic s);
        rd_sda = b;
        #40 wr_scl = 1'b1;
        #40 s = sda_w;
        #40 wr_scl = 1'b0;
        #40;
    endtask : ser_bit
    task automatic ser_start;
        rd_sda = 1'b1;
        #40 wr_scl = 1'b1;
        #80 rd_sda = 1'b0;
        #80 wr_scl = 1'b0;
        #40;
    endtask : ser_start
    task automatic ser_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) ser_bit(b[i], s);
        ser_bit(1'b1, s);
        ack = ~s;
    endtask : ser_byte
    task automatic ser_rbyte(input logic nack, output logic [7:0] q);
        logic s;
        for (int i = 0; i < 8; i++) begin
            ser_bit(1'b1, s);
            q = {q[6:0], s};
        end
        ser_bit(nack, s);
    endtask : ser_rbyte
    // address and index, then two data bytes or a repeated start and two reads, the last one refused
    task automatic ser_frame(input logic [6:0] dev, input logic [7:0] idx, input logic rd,
                             input logic [15:0] d, output logic [15:0] q, output logic [2:0] ack);
        logic a;
        ser_start();
        ser_byte({dev, 1'b0}, ack[2]);
        ser_byte(idx, ack[1]);
        if (rd) begin
            ser_start();
            ser_byte({dev, 1'b1}, ack[0]);
            ser_rbyte(1'b0, q[15:8]);
            ser_rbyte(1'b1, q[7:0]);
        end else begin
            ser_byte(d[15:8], ack[0]);
            ser_byte(d[7:0], a);
            ack[0] = ack[0] & a;
        end
        rd_sda = 1'b0;
        #40 wr_scl = 1'b1;
        #80 rd_sda = 1'b1;
        #80;
    endtask : ser_frame
endmodule : hpcb_host

// [testbench/testbench.sv]
// self-checking bench for the control bus interface in both modes
`timescale 1ns/1ps
module testbench;
    localparam int LIMIT = 5000;
    logic        clk;
    logic        rstn = 1'b0;
    logic        mode = 1'b0;
    logic        cs_n, rd_sda, wr_scl, sda_o, sda_oe, data_oe, reg_we;
    logic  [4:0] addr, reg_idx, we_idx;
    logic  [7:0] hd, data_o, reg_wdata, we_dat;
    int          failures, comparisons, we_cnt, oe_cnt, soe_cnt, cycles;
    // open-drain sda with pull-up; data bus shared by device and host
    wire         sda_w  = rd_sda & (~sda_oe | sda_o);
    wire   [7:0] data_w = data_oe ? data_o : hd;

    hpcb_top hpcb_top_i (
        .CLK(clk), .RSTN(rstn), .INTERFACE_SELECT(mode),
        .REG_INDEX_LO_OR_SERIAL_ADDR_STRAP0(addr[0]), .REG_INDEX_MID_OR_SERIAL_ADDR_STRAP1(addr[1]),
        .REG_INDEX_HI_OR_SERIAL_ADDR_STRAP2(addr[2]), .SLOT_SELECT_LO_OR_SERIAL_ADDR_STRAP3(addr[3]),
        .SLOT_SELECT_HI_OR_SERIAL_ADDR_STRAP4(addr[4]), .CS_N(cs_n), .RD_SDA_I(sda_w),
        .RD_SDA_O(sda_o), .RD_SDA_OE(sda_oe), .WR_SCL(wr_scl), .DATA_I(data_w), .DATA_O(data_o),
        .DATA_OE(data_oe), .REG_WE(reg_we), .REG_IDX(reg_idx), .REG_WDATA(reg_wdata)
    );
    hpcb_host hpcb_host_i (
        .clk(clk), .sda_w(sda_w), .data_w(data_w), .cs_n(cs_n), .rd_sda(rd_sda),
        .wr_scl(wr_scl), .addr(addr), .hd(hd)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (reg_we === 1'b1) begin
            we_cnt++;
            we_idx = reg_idx;
            we_dat = reg_wdata;
        end
        if (rstn && data_oe !== 1'b0) oe_cnt++;
        if (rstn && sda_oe !== 1'b0) soe_cnt++;
        if (cycles == LIMIT) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic do_reset(input logic m);
        @(negedge clk);
        rstn = 1'b0;
        mode = m;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
    endtask : do_reset

    task automatic test_parallel;
        logic [7:0] q;
        int         we0;
        int         oe0;
        hpcb_host_i.par_cycle(5'h1f, 8'h00, 1'b0, 1'b1, q);
        check(16'(q), 16'h0000);
        we0 = we_cnt;
        oe0 = oe_cnt;
        for (int i = 0; i < 32; i++) begin
            hpcb_host_i.par_cycle(i[4:0], {i[2:0], ~i[4:0]}, 1'b0, 1'b0, q);
            check(16'({we_idx, we_dat}), 16'({i[4:0], i[2:0], ~i[4:0]}));
        end
        check(16'(we_cnt - we0), 16'd32);
        check(16'(oe_cnt - oe0), 16'd0);
        for (int i = 31; i >= 0; i--) begin
            hpcb_host_i.par_cycle(i[4:0], 8'h00, 1'b0, 1'b1, q);
            check(16'(q), 16'({i[2:0], ~i[4:0]}));
        end
        check(16'(soe_cnt), 16'd0);
        $display("test_parallel finished");
    endtask : test_parallel

    task automatic test_chip_select;
        logic [7:0] q;
        int         we0;
        int         oe0;
        we0 = we_cnt;
        oe0 = oe_cnt;
        hpcb_host_i.par_cycle(5'h09, 8'hee, 1'b1, 1'b0, q);
        hpcb_host_i.par_cycle(5'h09, 8'h00, 1'b1, 1'b1, q);
        check(16'(we_cnt - we0), 16'd0);
        check(16'(oe_cnt - oe0), 16'd0);
        hpcb_host_i.par_cycle(5'h09, 8'h00, 1'b0, 1'b1, q);
        check(16'(q), 16'h0036);
        $display("test_chip_select finished");
    endtask : test_chip_select

    task automatic test_serial;
        logic [15:0] q;
        logic  [2:0] ack;
        logic        s;
        int          we0;
        int          oe0;
        hpcb_host_i.straps(7'h5b);
        do_reset(1'b1);
        // skew the link clock against the host clock
        #13;
        repeat (3) hpcb_host_i.ser_bit(1'b1, s);
        we0 = we_cnt;
        oe0 = oe_cnt;
        hpcb_host_i.ser_frame(7'h1b, 8'h13, 1'b0, 16'h1122, q, ack);
        check(16'(ack), 16'h0000);
        hpcb_host_i.ser_frame(7'h5b, 8'he3, 1'b0, 16'hc1d2, q, ack);
        repeat (8) @(negedge clk);
        check(16'(ack), 16'h0007);
        check(16'(we_cnt - we0), 16'd2);
        check(16'({we_idx, we_dat}), 16'h04d2);
        hpcb_host_i.ser_frame(7'h5b, 8'h03, 1'b1, 16'h0000, q, ack);
        check(16'(ack), 16'h0007);
        check(q, 16'hc1d2);
        check(16'(oe_cnt - oe0), 16'd0);
        $display("test_serial finished");
    endtask : test_serial

    task automatic complete_run;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    initial begin
        do_reset(1'b0);
        test_parallel();
        test_chip_select();
        test_serial();
        complete_run();
    end
endmodule : testbench
